/* i2c_host.sv */
// controller end: byte-level two-wire master driven from a small command port
`timescale 1ns/1ps
module i2c_host #(
  parameter int QUARTER = sens_pkg::FAST_QUARTER_CYC,
  parameter int INIT_CYCLES = sens_pkg::INIT_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  i2c_link_if.host link,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output logic dev_irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    sens_pkg::hst_t hst; // operation in progress
    logic [1:0] ph; // quarter of the bit
    logic [7:0] qc; // cycles within a quarter
    logic [3:0] bitn; // bit of the byte, 8 is the ack slot
    logic rd; // byte is a read
    logic nack_cmd; // answer nack after a read
    logic got_nack; // target refused last written byte
    logic [7:0] tx, rx;
    logic [23:0] icnt; // init hold-off counter
    logic ready; // device init has elapsed
    logic [1:0] sda_s, int_s; // synchronisers
    logic scl_oe, sda_oe;
    logic [7:0] rdata;
  } host_t;
  host_t s_q, s_d;
  logic busy;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    busy = s_q.hst != sens_pkg::H_IDLE;
    s_d.sda_s = {s_q.sda_s[0], link.sda};
    s_d.int_s = {s_q.int_s[0], link.int_n};
    // hold off all traffic until the sensor has initialised
    if (!s_q.ready) begin
      s_d.icnt = s_q.icnt + 24'h1;
      if (s_q.icnt == 24'(INIT_CYCLES - 1)) s_d.ready = 1'b1;
    end
    // command port: commands while busy or before ready are dropped
    if (wr_stb) begin
      case (addr)
        sens_pkg::H_TX: s_d.tx = wdata;
        sens_pkg::H_CMD: if (!busy && s_q.ready) begin
          s_d.ph = 2'h0;
          s_d.qc = 8'h00;
          s_d.bitn = 4'h0;
          s_d.nack_cmd = wdata[sens_pkg::C_NACK];
          s_d.rd = wdata[sens_pkg::C_RD];
          if (wdata[sens_pkg::C_START]) s_d.hst = sens_pkg::H_START;
          else if (wdata[sens_pkg::C_STOP]) s_d.hst = sens_pkg::H_STOP;
          else if (wdata[sens_pkg::C_WR] || wdata[sens_pkg::C_RD]) begin
            s_d.hst = sens_pkg::H_BYTE;
            if (wdata[sens_pkg::C_WR]) s_d.got_nack = 1'b0;
          end
        end
        default: s_d.hst = s_q.hst; // read-only words
      endcase
    end
    if (rd_stb) begin // answer one cycle later
      case (addr)
        sens_pkg::H_TX: s_d.rdata = s_q.tx;
        sens_pkg::H_RX: s_d.rdata = s_q.rx;
        sens_pkg::H_STAT: s_d.rdata = {4'h0, dev_irq, s_q.ready, s_q.got_nack, busy};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // bit engine: actions at the first cycle of each quarter
    if (busy) begin
      s_d.qc = s_q.qc + 8'h01;
      if (s_q.qc == 8'(QUARTER - 1)) begin
        s_d.qc = 8'h00;
        s_d.ph = s_q.ph + 2'h1;
      end
      if (s_q.qc == 8'h00) begin
        case (s_q.hst)
          sens_pkg::H_START: begin // data falls while clock high
            case (s_q.ph)
              2'h0: s_d.sda_oe = 1'b0;
              2'h1: s_d.scl_oe = 1'b0;
              2'h2: s_d.sda_oe = 1'b1;
              default: s_d.scl_oe = 1'b1;
            endcase
          end
          sens_pkg::H_STOP: begin // data rises while clock high
            case (s_q.ph)
              2'h0: s_d.sda_oe = 1'b1;
              2'h1: s_d.scl_oe = 1'b0;
              2'h2: s_d.sda_oe = 1'b0;
              default: s_d.scl_oe = 1'b0;
            endcase
          end
          default: begin // one bit of a byte or its ack slot
            case (s_q.ph)
              2'h0: begin
                if (s_q.bitn == 4'h8) s_d.sda_oe = s_q.rd & ~s_q.nack_cmd;
                else s_d.sda_oe = ~s_q.rd & ~s_q.tx[7];
              end
              2'h1: s_d.scl_oe = 1'b0;
              2'h2: begin
                if (s_q.bitn != 4'h8) s_d.rx = {s_q.rx[6:0], s_q.sda_s[1]};
                else if (!s_q.rd) s_d.got_nack = s_q.sda_s[1];
              end
              default: begin
                s_d.scl_oe = 1'b1;
                s_d.bitn = s_q.bitn + 4'h1;
                if (s_q.bitn != 4'h8 && !s_q.rd) s_d.tx = {s_q.tx[6:0], 1'b1};
              end
            endcase
          end
        endcase
      end
      // finish after the last quarter
      if (s_q.qc == 8'(QUARTER - 1) && s_q.ph == 2'h3
          && (s_q.hst != sens_pkg::H_BYTE || s_q.bitn == 4'h9)) begin
        s_d.hst = sens_pkg::H_IDLE;
        if (s_q.hst == sens_pkg::H_BYTE) s_d.sda_oe = 1'b0;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.hst <= sens_pkg::H_IDLE;
      s_q.sda_s <= 2'h3;
      s_q.int_s <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.scl_h_val = 1'b0;
  assign link.scl_h_oe = s_q.scl_oe;
  assign link.sda_h_val = 1'b0;
  assign link.sda_h_oe = s_q.sda_oe;
  assign rdata = s_q.rdata;
  assign dev_irq = s_q.ready & ~s_q.int_s[1];
endmodule

/* i2c_link_if.sv */
// two-wire link between controller and sensor, with open-drain wire resolution
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_h_val, scl_h_oe; // controller clock drive
  logic sda_h_val, sda_h_oe; // controller data drive
  logic sda_d_val, sda_d_oe; // sensor data drive
  logic int_d_val, int_d_oe; // sensor interrupt drive
  logic scl, sda, int_n; // resolved wire levels, pulled up
  assign scl = scl_h_oe ? scl_h_val : 1'b1;
  assign sda = (sda_h_oe ? sda_h_val : 1'b1) & (sda_d_oe ? sda_d_val : 1'b1);
  assign int_n = int_d_oe ? int_d_val : 1'b1;
  modport host (output scl_h_val, scl_h_oe, sda_h_val, sda_h_oe, input sda, int_n);
  modport dev (output sda_d_val, sda_d_oe, int_d_val, int_d_oe, input scl, sda);
endinterface

/* sens_pkg.sv */
// shared constants, register map and state encodings for the spectral sensor link
package sens_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 10; // system clock period
  localparam int BASE_TICK_NS = 2780; // integration base tick, 2.78 us
  localparam int BASE_TICK_CYC = (BASE_TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_US = 200; // power-on initialisation period
  localparam int INIT_CYC = INIT_US * 1000 / CLK_NS;
  localparam int FAST_SCL_NS = 2500; // 400 kHz serial clock period
  localparam int FAST_QUARTER_CYC = (FAST_SCL_NS / 4 + CLK_NS - 1) / CLK_NS;
  localparam int STD_SCL_NS = 10000; // 100 kHz serial clock period
  localparam int STD_QUARTER_CYC = (STD_SCL_NS / 4 + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] TARGET_ADDR_DFLT = 7'h39; // default target address
  localparam int CH_N = 6; // converter count
  // ****************************************
  // device register offsets
  // ****************************************
  localparam logic [7:0] R_ENABLE = 8'h80;
  localparam logic [7:0] R_STEPS = 8'h81;
  localparam logic [7:0] R_WAIT = 8'h83;
  localparam logic [7:0] R_THL_L = 8'h84;
  localparam logic [7:0] R_THH_L = 8'h86;
  localparam logic [7:0] R_STATUS = 8'h93;
  localparam logic [7:0] R_DATA_L = 8'h95;
  localparam logic [7:0] R_SAI_ST = 8'hA7;
  localparam logic [7:0] R_SAI_CTL = 8'hAC;
  localparam logic [7:0] R_GPIO_CFG = 8'hC0;
  localparam logic [7:0] R_GAIN = 8'hC6;
  localparam logic [7:0] R_STEP_SZ_L = 8'hCA;
  localparam logic [7:0] R_INT_EN = 8'hF9;
  localparam logic [7:0] R_SAI_CLR = 8'hFA;
  // ****************************************
  // device field positions and reset values
  // ****************************************
  localparam int EN_PON = 0; // power_on_bit
  localparam int EN_MEAS = 1; // measure_enable_bit
  localparam int EN_WAIT = 3; // wait between cycles
  localparam int ST_THR = 3; // threshold event, write 1 to clear
  localparam int ST_VALID = 6; // a result has been stored
  localparam int SAI_BIT = 4; // sleep_after_irq_bit in R_SAI_CTL
  localparam int SAI_ACT_BIT = 0; // irq_sleep_active_flag in R_SAI_ST / R_SAI_CLR
  localparam int INT_EN_BIT = 3; // threshold interrupt enable
  localparam int G_SYNC_IN = 0; // 1: pin is sync input, 0: output
  localparam int G_OUT_VAL = 1; // level driven in output mode
  localparam int G_LED_SYNC = 2; // led_sink_driver gated by pin
  localparam int G_LED_EN = 3; // led_sink_driver enable
  localparam logic [7:0] GPIO_CFG_RST = 8'h02; // output, released high
  localparam logic [7:0] STEP_SZ_RST_L = 8'hE7; // step size reset 999
  localparam logic [7:0] STEP_SZ_RST_H = 8'h03;
  // ****************************************
  // host command port
  // ****************************************
  localparam logic [1:0] H_CMD = 2'h0;
  localparam logic [1:0] H_TX = 2'h1;
  localparam logic [1:0] H_RX = 2'h2;
  localparam logic [1:0] H_STAT = 2'h3;
  localparam int C_START = 0;
  localparam int C_STOP = 1;
  localparam int C_WR = 2;
  localparam int C_RD = 3;
  localparam int C_NACK = 4;
  // ****************************************
  // state encodings
  // ****************************************
  typedef enum logic [3:0] {
    P_INIT = 4'b0001, P_SLEEP = 4'b0010, P_IDLE = 4'b0100, P_ACTIVE = 4'b1000
  } pwr_t;
  typedef enum logic [5:0] {
    I_IDLE = 6'b000001, I_DEV = 6'b000010, I_ACK = 6'b000100,
    I_WR = 6'b001000, I_RD = 6'b010000, I_RACK = 6'b100000
  } tgt_t;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001, H_START = 4'b0010, H_STOP = 4'b0100, H_BYTE = 4'b1000
  } hst_t;
endpackage

/* sensor_dev.sv */
// sensor end: serial target, register file, power states and measurement sequencer
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module sensor_dev #(
  parameter int INIT_CYCLES = sens_pkg::INIT_CYC,
  parameter logic [6:0] TARGET_ADDR = sens_pkg::TARGET_ADDR_DFLT
) (
  input wire logic mclk,
  input wire logic rst_n,
  i2c_link_if.dev link,
  input wire logic [16*sens_pkg::CH_N-1:0] light_in,
  input wire logic gpio_sense,
  output logic gpio_val,
  output logic gpio_oe,
  output logic led_on,
  output logic osc_on
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    sens_pkg::pwr_t pst; // power state
    logic [23:0] icnt; // init counter
    logic [2:0] scl_s; // [0] first flop, [1] second, [2] previous
    logic [2:0] sda_s;
    logic [1:0] gp_s; // pin synchroniser
    sens_pkg::tgt_t ist; // serial target state
    logic [3:0] cnt; // bit counter
    logic [7:0] sh; // receive shift
    logic [7:0] tx; // transmit shift
    logic [7:0] ptr; // register pointer
    logic [7:0] lat; // high byte latched by a low-byte read
    logic [7:0] wlo; // low byte waiting for its high byte
    logic have_ptr; // pointer byte seen in this transfer
    logic rw; // direction of transfer
    logic nak; // end after this ack slot
    logic sda_oe;
    logic [7:0] en, steps, wtime, stat, gcfg;
    logic [15:0] stsz, thl, thh;
    logic [3:0] gain;
    logic sleep_after_irq_bit, sai_act, intena;
    logic [sens_pkg::CH_N-1:0][15:0] data; // results
    logic mph; // 0 integrating, 1 waiting
    logic [8:0] tick;
    logic [15:0] sz;
    logic [7:0] st;
  } dev_t;
  dev_t s_q, s_d;

  // ****************************************
  // register helpers
  // ****************************************
  // low byte of a two-byte field
  function automatic logic lo16(input logic [7:0] a);
    return a == sens_pkg::R_THL_L || a == sens_pkg::R_THH_L || a == sens_pkg::R_STEP_SZ_L
      || (a >= sens_pkg::R_DATA_L && a < sens_pkg::R_DATA_L + 8'(2 * sens_pkg::CH_N)
      && a[0] == sens_pkg::R_DATA_L[0]);
  endfunction

  // plain register read, high halves undelayed
  function automatic logic [7:0] rd(input dev_t s, input logic [7:0] a);
    logic [7:0] off;
    off = a - sens_pkg::R_DATA_L;
    if (a >= sens_pkg::R_DATA_L && a < sens_pkg::R_DATA_L + 8'(2 * sens_pkg::CH_N))
      return off[0] ? s.data[off[3:1]][15:8] : s.data[off[3:1]][7:0];
    case (a)
      sens_pkg::R_ENABLE: return s.en;
      sens_pkg::R_STEPS: return s.steps;
      sens_pkg::R_WAIT: return s.wtime;
      sens_pkg::R_THL_L: return s.thl[7:0];
      sens_pkg::R_THL_L + 8'h01: return s.thl[15:8];
      sens_pkg::R_THH_L: return s.thh[7:0];
      sens_pkg::R_THH_L + 8'h01: return s.thh[15:8];
      sens_pkg::R_STATUS: return s.stat;
      sens_pkg::R_SAI_ST: return 8'(s.sai_act) << sens_pkg::SAI_ACT_BIT;
      sens_pkg::R_SAI_CTL: return 8'(s.sleep_after_irq_bit) << sens_pkg::SAI_BIT;
      sens_pkg::R_GPIO_CFG: return s.gcfg;
      sens_pkg::R_GAIN: return {4'h0, s.gain};
      sens_pkg::R_STEP_SZ_L: return s.stsz[7:0];
      sens_pkg::R_STEP_SZ_L + 8'h01: return s.stsz[15:8];
      sens_pkg::R_INT_EN: return 8'(s.intena) << sens_pkg::INT_EN_BIT;
      default: return 8'h00; // unmapped reads zero
    endcase
  endfunction

  // fetch next byte to send, latching two-byte fields
  function automatic dev_t load(input dev_t s);
    dev_t r;
    r = s;
    r.tx = lo16(s.ptr - 8'h01) ? s.lat : rd(s, s.ptr);
    if (lo16(s.ptr)) r.lat = rd(s, s.ptr + 8'h01);
    r.ptr = s.ptr + 8'h01;
    return r;
  endfunction

  // register write; two-byte fields commit on the high byte
  function automatic dev_t wr(input dev_t s, input logic [7:0] a, input logic [7:0] w);
    dev_t r;
    r = s;
    if (lo16(a)) r.wlo = w;
    case (a)
      sens_pkg::R_ENABLE: r.en = w;
      sens_pkg::R_STEPS: r.steps = w;
      sens_pkg::R_WAIT: r.wtime = w;
      sens_pkg::R_STATUS: r.stat = s.stat & ~w; // write one to clear
      sens_pkg::R_SAI_CTL: r.sleep_after_irq_bit = w[sens_pkg::SAI_BIT];
      sens_pkg::R_SAI_CLR: if (w[sens_pkg::SAI_ACT_BIT]) r.sai_act = 1'b0;
      sens_pkg::R_GPIO_CFG: r.gcfg = w;
      sens_pkg::R_GAIN: r.gain = w[3:0];
      sens_pkg::R_INT_EN: r.intena = w[sens_pkg::INT_EN_BIT];
      sens_pkg::R_THL_L + 8'h01: r.thl = {w, s.wlo};
      sens_pkg::R_THH_L + 8'h01: r.thh = {w, s.wlo};
      sens_pkg::R_STEP_SZ_L + 8'h01: r.stsz = {w, s.wlo};
      default: r.en = s.en; // read-only or unmapped: ignored
    endcase
    return r;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  logic rise, fall, start, stop, sda_now, run, thr;
  logic [31:0] sc;
  always_comb begin
    s_d = s_q;
    sc = 32'h0;
    thr = 1'b0;
    // synchronisers: first flop feeds only the second
    s_d.scl_s = {s_q.scl_s[1:0], link.scl};
    s_d.sda_s = {s_q.sda_s[1:0], link.sda};
    s_d.gp_s = {s_q.gp_s[0], gpio_sense};
    sda_now = s_q.sda_s[1];
    rise = s_q.scl_s[1] & ~s_q.scl_s[2];
    fall = ~s_q.scl_s[1] & s_q.scl_s[2];
    start = s_q.scl_s[1] & s_q.scl_s[2] & s_q.sda_s[2] & ~sda_now;
    stop = s_q.scl_s[1] & s_q.scl_s[2] & ~s_q.sda_s[2] & sda_now;
    // serial target, alive in every power state
    if (start) begin
      s_d.ist = sens_pkg::I_DEV;
      s_d.cnt = 4'h0;
      s_d.have_ptr = 1'b0;
      s_d.sda_oe = 1'b0;
    end else if (stop) begin // pointer survives stop
      s_d.ist = sens_pkg::I_IDLE;
      s_d.sda_oe = 1'b0;
    end else begin
      case (s_q.ist)
        sens_pkg::I_DEV, sens_pkg::I_WR: begin
          if (rise) begin // sample on rising clock
            s_d.sh = {s_q.sh[6:0], sda_now};
            s_d.cnt = s_q.cnt + 4'h1;
          end
          if (fall && s_q.cnt == 4'h8) begin // ninth clock: ack slot
            s_d.ist = sens_pkg::I_ACK;
            s_d.nak = 1'b0;
            if (s_q.ist == sens_pkg::I_DEV) begin
              // nack foreign addresses and everything during init
              s_d.nak = s_q.sh[7:1] != TARGET_ADDR || s_q.pst == sens_pkg::P_INIT;
              s_d.rw = s_q.sh[0];
            end else if (!s_q.have_ptr) begin // first byte is the pointer
              s_d.ptr = s_q.sh;
              s_d.have_ptr = 1'b1;
            end else begin
              s_d = wr(s_d, s_q.ptr, s_q.sh);
              s_d.ptr = s_q.ptr + 8'h01;
            end
            s_d.sda_oe = ~s_d.nak;
          end
        end
        sens_pkg::I_ACK: if (fall) begin
          s_d.sda_oe = 1'b0;
          s_d.cnt = 4'h0;
          if (s_q.nak) s_d.ist = sens_pkg::I_IDLE; // ignore rest of transfer
          else if (s_q.rw) begin
            s_d = load(s_d);
            s_d.sda_oe = ~s_d.tx[7];
            s_d.cnt = 4'h1;
            s_d.ist = sens_pkg::I_RD;
          end else s_d.ist = sens_pkg::I_WR;
        end
        sens_pkg::I_RD: if (fall) begin
          if (s_q.cnt == 4'h8) begin // release for host ack
            s_d.sda_oe = 1'b0;
            s_d.ist = sens_pkg::I_RACK;
          end else begin
            s_d.tx = {s_q.tx[6:0], 1'b0};
            s_d.sda_oe = ~s_q.tx[6];
            s_d.cnt = s_q.cnt + 4'h1;
          end
        end
        sens_pkg::I_RACK: begin
          if (rise) s_d.nak = sda_now;
          if (fall) begin
            if (s_q.nak) s_d.ist = sens_pkg::I_IDLE;
            else begin
              s_d = load(s_d);
              s_d.sda_oe = ~s_d.tx[7];
              s_d.cnt = 4'h1;
              s_d.ist = sens_pkg::I_RD;
            end
          end
        end
        default: s_d.ist = sens_pkg::I_IDLE;
      endcase
    end
    // measurement sequencer; runs after register writes so events win over clears
    run = s_q.pst == sens_pkg::P_ACTIVE
      && (!s_q.gcfg[sens_pkg::G_SYNC_IN] || s_q.gp_s[1]);
    if (!run) begin // restart cleanly on next enable
      s_d.mph = 1'b0;
      s_d.tick = 9'h000;
      s_d.sz = 16'h0000;
      s_d.st = 8'h00;
    end else begin
      s_d.tick = s_q.tick + 9'h001;
      if (s_q.tick == 9'(sens_pkg::BASE_TICK_CYC - 1)) begin
        s_d.tick = 9'h000;
        s_d.sz = s_q.sz + 16'h0001;
        if (s_q.sz == s_q.stsz) begin
          s_d.sz = 16'h0000;
          s_d.st = s_q.st + 8'h01;
          if (s_q.st == (s_q.mph ? s_q.wtime : s_q.steps)) begin
            s_d.st = 8'h00;
            s_d.mph = ~s_q.mph & s_q.en[sens_pkg::EN_WAIT];
            if (!s_q.mph) begin // end of integration: store all channels
              for (int i = 0; i < sens_pkg::CH_N; i++) begin
                sc = 32'(light_in[16*i +: 16]) << s_q.gain;
                s_d.data[i] = |sc[31:16] ? 16'hFFFF : sc[15:0];
              end
              s_d.stat[sens_pkg::ST_VALID] = 1'b1;
              thr = s_d.data[0] < s_q.thl || s_d.data[0] > s_q.thh;
            end
          end
        end
      end
    end
    if (thr) s_d.stat[sens_pkg::ST_THR] = 1'b1;
    if (thr && s_q.intena && s_q.sleep_after_irq_bit) s_d.sai_act = 1'b1;
    // power states; registers stay untouched by interrupt sleep
    case (s_q.pst)
      sens_pkg::P_INIT: begin
        s_d.icnt = s_q.icnt + 24'h1;
        if (s_q.icnt == 24'(INIT_CYCLES - 1)) s_d.pst = sens_pkg::P_SLEEP;
      end
      default: begin
        if (s_q.sai_act || !s_q.en[sens_pkg::EN_PON]) s_d.pst = sens_pkg::P_SLEEP;
        else if (s_q.en[sens_pkg::EN_MEAS]) s_d.pst = sens_pkg::P_ACTIVE;
        else s_d.pst = sens_pkg::P_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.pst <= sens_pkg::P_INIT;
      s_q.ist <= sens_pkg::I_IDLE;
      s_q.scl_s <= 3'h7;
      s_q.sda_s <= 3'h7;
      s_q.gcfg <= sens_pkg::GPIO_CFG_RST;
      s_q.stsz <= {sens_pkg::STEP_SZ_RST_H, sens_pkg::STEP_SZ_RST_L};
      s_q.thh <= 16'hFFFF;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // open-drain pins only ever pull low
  assign link.sda_d_val = 1'b0;
  assign link.sda_d_oe = s_q.sda_oe;
  assign link.int_d_val = 1'b0;
  assign link.int_d_oe = s_q.stat[sens_pkg::ST_THR] & s_q.intena;
  assign gpio_val = 1'b0;
  assign gpio_oe = ~s_q.gcfg[sens_pkg::G_SYNC_IN] & ~s_q.gcfg[sens_pkg::G_OUT_VAL];
  assign led_on = run & s_q.gcfg[sens_pkg::G_LED_EN]
    & (~s_q.gcfg[sens_pkg::G_LED_SYNC] | s_q.gp_s[1]);
  assign osc_on = s_q.pst == sens_pkg::P_IDLE || s_q.pst == sens_pkg::P_ACTIVE;
endmodule

/* sensor_link_sva.sv */
// assertions on the two-wire link between controller and sensor
`timescale 1ns/1ps
module sensor_link_sva #(
  parameter int INIT_CYCLES = 20000
) (
  input logic mclk,
  input logic rst_n,
  input logic sda_d_val,
  input logic sda_d_oe,
  input logic int_d_val,
  input logic int_d_oe,
  input logic scl
);
  logic [31:0] age_q; // edges since reset release, saturating
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) age_q <= 32'h0;
    else if (age_q < INIT_CYCLES) age_q <= age_q + 32'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_init_sda; age_q < INIT_CYCLES - 1 |-> !sda_d_oe; endproperty
  a_init_sda: assert property (p_init_sda) else $error("sda driven in init");
  property p_init_int; age_q < INIT_CYCLES - 1 |-> !int_d_oe; endproperty
  a_init_int: assert property (p_init_int) else $error("int driven in init");
  property p_sda_od; sda_d_oe |-> !sda_d_val; endproperty
  a_sda_od: assert property (p_sda_od) else $error("sda driven high");
  property p_int_od; int_d_oe |-> !int_d_val; endproperty
  a_int_od: assert property (p_int_od) else $error("int driven high");
  property p_ack_low; $rose(sda_d_oe) |-> !scl; endproperty
  a_ack_low: assert property (p_ack_low) else $error("drive while clock high");
  property p_rel_low; $fell(sda_d_oe) |-> !scl; endproperty
  a_rel_low: assert property (p_rel_low) else $error("release while clock high");
  property p_hold; scl && $past(scl) |-> $stable(sda_d_oe); endproperty
  a_hold: assert property (p_hold) else $error("data moved in clock high");
  property p_scl_low; $fell(scl) |-> !scl [*6]; endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low too short");
endmodule

/* spectral_sensor_i2c_power_ctrl_test.sv */
// bench: controller and sensor joined over the two-wire link
`timescale 1ns/1ps
module spectral_sensor_i2c_power_ctrl_test;
  localparam int INIT = 50; // shortened init hold-off
  localparam logic [7:0] DEV_W = {sens_pkg::TARGET_ADDR_DFLT, 1'b0};
  logic mclk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, st;
  logic [15:0] v;
  logic [31:0] t;
  logic [95:0] light_in = 96'h0; // raw converter values
  logic dev_irq, osc_on, gpio_val, gpio_oe, led_on;
  logic gpio_sense = 1'b0; // sync pin level, low until the gating scenario
  int seed = 32'h2359, fail_count = 0, check_count = 0;
  i2c_link_if link_bus();
  sensor_dev #(.INIT_CYCLES(INIT)) u_sensor_dev (.mclk(mclk), .rst_n(rst_n), .link(link_bus),
    .light_in(light_in), .gpio_sense(gpio_sense), .gpio_val(gpio_val), .gpio_oe(gpio_oe),
    .led_on(led_on), .osc_on(osc_on));
  i2c_host #(.QUARTER(4), .INIT_CYCLES(INIT)) u_i2c_host (.mclk(mclk), .rst_n(rst_n),
    .link(link_bus), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .dev_irq(dev_irq));
  sensor_link_sva #(.INIT_CYCLES(INIT)) u_sensor_link_sva (.mclk(mclk), .rst_n(rst_n),
    .sda_d_val(link_bus.sda_d_val), .sda_d_oe(link_bus.sda_d_oe), .scl(link_bus.scl),
    .int_d_val(link_bus.int_d_val), .int_d_oe(link_bus.int_d_oe));
  initial forever #5 mclk = ~mclk;
  // one port cycle; a read leaves its answer in st
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= w;
    rd_stb <= !w;
    @(posedge mclk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    #1 st = rdata;
  endtask
  // load a byte, issue a command, poll busy under a bound
  task automatic op(input logic [7:0] c, input logic [7:0] b);
    bus(1'b1, 2'h1, b);
    bus(1'b1, 2'h0, c);
    st = 8'hFF;
    for (int n = 0; n < 300 && st[0] !== 1'b0; n++) bus(1'b0, 2'h3, 8'h00);
    chk(st[0], 1'b0);
  endtask
  // n>0 writes n bytes; 0 reads two bytes; <0 reads two without pointer
  task automatic tr(input logic [7:0] r, input logic [31:0] d, input int n);
    op(8'h01, 8'h00);
    if (n >= 0) begin
      op(8'h04, DEV_W);
      op(8'h04, r);
      for (int i = 0; i < n; i++) op(8'h04, d[8*i+:8]);
      if (n == 0) op(8'h01, 8'h00);
    end
    if (n <= 0) begin
      op(8'h04, DEV_W | 8'h01);
      op(8'h08, 8'h00);
      bus(1'b0, 2'h2, 8'h00);
      v[7:0] = st;
      op(8'h18, 8'h00);
      bus(1'b0, 2'h2, 8'h00);
      v[15:8] = st;
    end
    op(8'h02, 8'h00);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #800000 fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    light_in <= {$random(seed), $random(seed), $random(seed)} & ~96'h8000;
    st = 8'h00;
    for (int n = 0; n < 300 && st[2] !== 1'b1; n++) bus(1'b0, 2'h3, 8'h00);
    chk(st[2], 1'b1);
    chk(osc_on, 1'b0);
    op(8'h01, 8'h00);
    op(8'h04, 8'h54);
    chk(st[1], 1'b1);
    op(8'h02, 8'h00);
    tr(8'hC0, 0, 0);
    chk(v, 16'h0002);
    t = $random(seed);
    tr(8'h84, t, 4);
    tr(8'h84, 0, 0);
    chk(v, t[15:0]);
    tr(8'h00, 0, -1);
    chk(v, t[31:16]);
    tr(8'h80, 1, 1);
    chk(osc_on, 1'b1);
    tr(8'h81, 0, 1);
    tr(8'hCA, 1, 2);
    tr(8'hC6, 0, 1);
    tr(8'hF9, 8, 1);
    tr(8'hAC, 16, 1);
    tr(8'h84, 32'hFFFFFFFF, 4);
    tr(8'h80, 3, 1);
    for (int n = 0; n < 2000 && dev_irq !== 1'b1; n++) @(posedge mclk);
    chk(dev_irq, 1'b1);
    chk(osc_on, 1'b0);
    tr(8'h80, 0, 0);
    chk(v, 16'h0003);
    tr(8'hA7, 0, 0);
    chk(v, 16'h0001);
    tr(8'h95, 0, 0);
    chk(v, light_in[15:0]);
    tr(8'hC0, 0, 1);
    chk({gpio_oe, gpio_val}, 2'b10);
    tr(8'hC0, 8'h0D, 1);
    chk(gpio_oe, 1'b0);
    tr(8'hFA, 1, 1);
    chk(osc_on, 1'b1);
    chk(led_on, 1'b0);
    @(posedge mclk);
    gpio_sense <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(led_on, 1'b1);
    gpio_sense <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(led_on, 1'b0);
    report_and_stop();
  end
endmodule
